// file: rtl/lgc_cell.sv
// one programmable logic cell: table, storage element, carry and cascade
// chains, output routing and an emulated internal tri-state bus
// assumes fabric inputs come from logic on clk_i and config over wishbone
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps

module lgc_cell
	import lgc_pkg::*;
#(
	parameter int BUS_DRIVERS = 4,
	parameter int CELLS       = CLUSTER_CELLS
) (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// wishbone register slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	output logic                        wb_err_o,
	// operand inputs from the cluster routing
	input  wire logic                   operand_in_1_i,
	input  wire logic                   operand_in_2_i,
	input  wire logic                   operand_in_3_i,
	input  wire logic                   operand_in_4_i,
	// register controls, active low
	input  wire logic                   clear_n_i,
	input  wire logic                   preset_n_i,
	input  wire logic                   chip_reset_n_i,
	// chains from the previous cell and toward the next ones
	input  wire lgc_chain_type          chain_i,
	output lgc_chain_type               chain_near_o,
	output lgc_chain_type               chain_far_o,
	// cell outputs
	output logic                        local_o,
	output logic                        global_o,
	// emulated tri-state bus
	input  wire logic [BUS_DRIVERS-1:0] bus_data_i,
	input  wire logic [BUS_DRIVERS-1:0] bus_en_i,
	output logic                        bus_o
);

	// refuse shapes the logic cannot serve
	if (BUS_DRIVERS < 1) begin : g_chk_bus
		$error("BUS_DRIVERS must be at least one");
	end
	if (CELLS < 2 || CELLS > 8) begin : g_chk_cells
		$error("CELLS must lie between two and eight");
	end

	localparam logic [2:0] LAST_IDX = 3'(CELLS - 1);

	// merge one 32-bit write under byte enables
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction

	// one bit out of an eight-entry half of the table
	function automatic logic half_lookup(input logic [TABLE_WIDTH-1:0] tbl,
		input logic upper, input logic [2:0] idx);
		logic [3:0] pos;
		pos = {upper, idx};
		return tbl[pos];
	endfunction

	logic [CTRL_WIDTH-1:0]  ctrl_q;
	logic [TABLE_WIDTH-1:0] table_q;
	logic                   ack_q;
	logic                   err_q;
	logic [31:0]            rdata_q;
	logic                   ff_q;

	// decoded configuration
	lgc_mode_type mode;
	lgc_ff_type   ff_kind;
	logic         run;
	logic [2:0]   cell_idx;

	assign mode     = lgc_mode_type'(ctrl_q[CTRL_MODE_LO +: 2]);
	assign ff_kind  = lgc_ff_type'(ctrl_q[CTRL_FF_LO +: 2]);
	assign run      = ctrl_q[CTRL_RUN];
	assign cell_idx = ctrl_q[CTRL_IDX_LO +: 3];

	// bus decode
	logic req;
	logic hit_ctrl;
	logic hit_table;
	logic hit_stat;
	logic mapped;

	assign req       = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
	assign hit_ctrl  = wb_adr_i == ADR_CTRL;
	assign hit_table = wb_adr_i == ADR_TABLE;
	assign hit_stat  = wb_adr_i == ADR_STATUS;
	assign mapped    = hit_ctrl | hit_table | hit_stat;

	// answer one cycle after the request, err on unmapped offsets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			ack_q <= req & mapped;
			err_q <= req & ~mapped;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;

	// control register; while running only the run bit may change
	logic [31:0] ctrl_wr;
	assign ctrl_wr = merge_bytes({14'h0000, ctrl_q}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RST;
		end else if (req & wb_we_i & hit_ctrl) begin
			if (run) begin
				ctrl_q[CTRL_RUN] <= ctrl_wr[CTRL_RUN];
			end else begin
				ctrl_q <= ctrl_wr[CTRL_WIDTH-1:0];
			end
		end
	end

	// table contents, frozen while running
	logic [31:0] table_wr;
	assign table_wr = merge_bytes({16'h0000, table_q}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			table_q <= TABLE_RST;
		end else if (req & wb_we_i & hit_table & ~run) begin
			table_q <= table_wr[TABLE_WIDTH-1:0];
		end
	end

	// chain inputs; a new chain after the midpoint ignores its neighbour
	logic carry_in;
	logic casc_in;
	logic casc_neutral;

	assign casc_neutral = ~ctrl_q[CTRL_CASC_OR];
	assign carry_in = ctrl_q[CTRL_CHAIN_NEW] ? 1'b0 : chain_i.carry;
	assign casc_in  = ctrl_q[CTRL_CHAIN_NEW] ? casc_neutral : chain_i.cascade;

	// four-input table, third input from carry-in or operand three
	logic       table_c;
	logic [3:0] table_idx;
	logic       table4;

	assign table_c   = ctrl_q[CTRL_CIN_SEL] ? carry_in : operand_in_3_i;
	assign table_idx = {operand_in_4_i, table_c, operand_in_2_i, operand_in_1_i};
	assign table4    = table_q[table_idx];

	// split tables for arithmetic and counters
	logic [2:0] arith_idx;
	logic [2:0] count_idx;
	logic       sum_bit;
	logic       sum_carry;
	logic       count_bit;
	logic       count_carry;

	assign arith_idx   = {operand_in_1_i, operand_in_2_i, carry_in};
	assign sum_bit     = half_lookup(table_q, 1'b0, arith_idx);
	assign sum_carry   = half_lookup(table_q, 1'b1, arith_idx);
	// operand four is direction or, in the clearable form, count enable
	assign count_idx   = {ff_q, operand_in_4_i, carry_in};
	assign count_bit   = half_lookup(table_q, 1'b0, count_idx);
	assign count_carry = half_lookup(table_q, 1'b1, count_idx);

	// combinational result of the cell per mode
	logic comb_out;
	logic carry_out;

	always_comb begin
		comb_out  = table4;
		carry_out = carry_in;
		case (mode)
			MODE_NORMAL: begin
				comb_out  = table4;
				carry_out = carry_in;
			end
			MODE_ARITH: begin
				comb_out  = sum_bit;
				carry_out = sum_carry;
			end
			MODE_UPDOWN, MODE_CLRCNT: begin
				comb_out  = count_bit;
				carry_out = count_carry;
			end
			default: begin
				comb_out  = table4;
				carry_out = carry_in;
			end
		endcase
	end

	// cascade: AND, or OR built from inverted AND; packed cells pass cascade-in through unchanged
	logic casc_join;
	logic casc_out;

	assign casc_join = ctrl_q[CTRL_CASC_OR] ? ~(~comb_out & ~casc_in) : (comb_out & casc_in);
	always_comb begin
		if (~ctrl_q[CTRL_CASC_EN] | ctrl_q[CTRL_PACK]) begin
			casc_out = casc_in;
		end else begin
			casc_out = casc_join;
		end
	end

	// data presented to the storage element
	logic load_mux;
	logic ff_data;

	assign load_mux = operand_in_3_i ? operand_in_2_i : count_bit;

	always_comb begin
		ff_data = comb_out;
		case (mode)
			MODE_NORMAL: begin
				ff_data = ctrl_q[CTRL_PACK] ? operand_in_4_i : table4;
			end
			MODE_ARITH: begin
				ff_data = sum_bit;
			end
			MODE_UPDOWN: begin
				ff_data = load_mux;
			end
			MODE_CLRCNT: begin
				ff_data = load_mux & casc_in;
			end
			default: begin
				ff_data = comb_out;
			end
		endcase
	end

	// flipflop behaviour; operand two is the K or R input
	logic ff_next;

	always_comb begin
		ff_next = ff_q;
		case (ff_kind)
			FF_D: ff_next = ff_data;
			FF_T: ff_next = ff_q ^ ff_data;
			FF_JK: begin
				case ({ff_data, operand_in_2_i})
					2'b10:   ff_next = 1'b1;
					2'b01:   ff_next = 1'b0;
					2'b11:   ff_next = ~ff_q;
					default: ff_next = ff_q;
				endcase
			end
			FF_SR: begin
				case ({ff_data, operand_in_2_i})
					2'b10:   ff_next = 1'b1;
					2'b01:   ff_next = 1'b0;
					default: ff_next = ff_q;
				endcase
			end
			default: ff_next = ff_q;
		endcase
	end

	// clock enable, from operand one when so configured
	logic ce;
	assign ce = run & (~ctrl_q[CTRL_CE_OP1] | operand_in_1_i);

	// storage element: chip reset, clear, preset, then enabled update
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ff_q <= 1'b0;
		end else if (ctrl_q[CTRL_CHIP_RST] & ~chip_reset_n_i) begin
			ff_q <= 1'b0;
		end else if (~clear_n_i) begin
			ff_q <= 1'b0;
		end else if (~preset_n_i) begin
			ff_q <= 1'b1;
		end else if (ce) begin
			ff_q <= ff_next;
		end
	end

	// output routing, each output its own choice
	assign local_o  = ctrl_q[CTRL_LOCAL_REG]  ? ff_q : comb_out;
	assign global_o = ctrl_q[CTRL_GLOBAL_REG] ? ff_q : comb_out;

	// chain outputs: next cell inside the cluster, or two clusters on
	logic at_last;
	assign at_last = cell_idx == LAST_IDX;

	always_comb begin
		chain_near_o = '0;
		chain_far_o  = '0;
		if (!at_last) begin
			chain_near_o.carry   = carry_out;
			chain_near_o.cascade = casc_out;
		end else if (!ctrl_q[CTRL_MID_LAST]) begin
			chain_far_o.carry   = carry_out;
			chain_far_o.cascade = casc_out;
		end
	end

	// emulated tri-state bus: count drivers, resolve contention and float
	logic [BUS_DRIVERS-1:0] drive_bits;
	logic                   many_on;
	logic                   any_on;

	assign drive_bits = bus_data_i & bus_en_i;
	assign any_on     = |bus_en_i;
	assign many_on    = (bus_en_i & (bus_en_i - 1'b1)) != '0;

	always_comb begin
		if (!any_on) begin
			bus_o = 1'b1;
		end else if (many_on) begin
			bus_o = 1'b0;
		end else begin
			bus_o = |drive_bits;
		end
	end

	// read data, captured with the answer
	logic [31:0] status_word;

	always_comb begin
		status_word               = 32'h0000_0000;
		status_word[STAT_TABLE]   = comb_out;
		status_word[STAT_REG]     = ff_q;
		status_word[STAT_LOCAL]   = local_o;
		status_word[STAT_GLOBAL]  = global_o;
		status_word[STAT_CARRY]   = carry_out;
		status_word[STAT_CASCADE] = casc_out;
		status_word[STAT_BUS]     = bus_o;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (req & ~wb_we_i) begin
			if (hit_ctrl) begin
				rdata_q <= {14'h0000, ctrl_q};
			end else if (hit_table) begin
				rdata_q <= {16'h0000, table_q};
			end else if (hit_stat) begin
				rdata_q <= status_word;
			end else begin
				rdata_q <= 32'h0000_0000;
			end
		end
	end

	assign wb_dat_o = rdata_q;

endmodule

// file: rtl/lgc_pkg.sv
// shared constants and types for the programmable logic cell
// assumes a 32-bit classic wishbone register bus and one clock
package lgc_pkg;

	// register byte offsets
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_TABLE  = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;

	// control register field positions
	localparam int CTRL_MODE_LO   = 0;  // 2 bits
	localparam int CTRL_FF_LO     = 2;  // 2 bits
	localparam int CTRL_CIN_SEL   = 4;
	localparam int CTRL_PACK      = 5;
	localparam int CTRL_LOCAL_REG = 6;
	localparam int CTRL_GLOBAL_REG = 7;
	localparam int CTRL_CASC_EN   = 8;
	localparam int CTRL_CASC_OR   = 9;
	localparam int CTRL_CE_OP1    = 10;
	localparam int CTRL_CHAIN_NEW = 11;
	localparam int CTRL_MID_LAST  = 12;
	localparam int CTRL_IDX_LO    = 13; // 3 bits
	localparam int CTRL_CHIP_RST  = 16;
	localparam int CTRL_RUN       = 17;
	localparam int CTRL_WIDTH     = 18;

	// status register field positions
	localparam int STAT_TABLE   = 0;
	localparam int STAT_REG     = 1;
	localparam int STAT_LOCAL   = 2;
	localparam int STAT_GLOBAL  = 3;
	localparam int STAT_CARRY   = 4;
	localparam int STAT_CASCADE = 5;
	localparam int STAT_BUS     = 6;

	// table layout: arithmetic and counter modes split the table in two
	localparam int TABLE_WIDTH   = 16;
	localparam int HALF_TABLE_LO = 8;

	// reset values
	localparam logic [CTRL_WIDTH-1:0]  CTRL_RST  = 18'h00000;
	localparam logic [TABLE_WIDTH-1:0] TABLE_RST = 16'h0000;

	// cells in one cluster
	localparam int CLUSTER_CELLS = 8;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_ARITH,
		MODE_UPDOWN,
		MODE_CLRCNT
	} lgc_mode_type;

	typedef enum logic [1:0] {
		FF_D,
		FF_T,
		FF_JK,
		FF_SR
	} lgc_ff_type;

	// carry and cascade travel together between neighbouring cells
	typedef struct packed {
		logic carry;
		logic cascade;
	} lgc_chain_type;

endpackage

// file: verification/lgc_cell_props.sv
// port checker for the logic cell: bus answers, emulated bus, chain outputs
// assumes it is bound to every lgc_cell instance
`timescale 1ns/1ps
module lgc_cell_props
	import lgc_pkg::*;
#(
	parameter int BUS_DRIVERS = 4
) (
	// clock, reset, register bus
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire logic                   wb_cyc_i,
	input wire logic                   wb_stb_i,
	input wire logic                   wb_ack_o,
	input wire logic                   wb_err_o,
	// chains and emulated bus
	input wire lgc_chain_type          chain_near_o,
	input wire lgc_chain_type          chain_far_o,
	input wire logic [BUS_DRIVERS-1:0] bus_data_i,
	input wire logic [BUS_DRIVERS-1:0] bus_en_i,
	input wire logic                   bus_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_req_gets_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o)
		else $error("request not answered next cycle");
	a_err_one_pulse: assert property (wb_err_o |=> !wb_err_o)
		else $error("error held longer than one cycle");
	a_bus_idle_high: assert property (bus_en_i == '0 |-> bus_o)
		else $error("undriven bus not high");
	a_bus_clash_low: assert property ($countones(bus_en_i) > 1 |-> !bus_o)
		else $error("contended bus not low");
	a_bus_one_drv: assert property ($onehot(bus_en_i) |-> bus_o == |(bus_en_i & bus_data_i))
		else $error("single driver not passed");
	a_bus_steady: assert property ($stable(bus_en_i) && $stable(bus_data_i) |-> $stable(bus_o))
		else $error("bus moved without cause");
	a_far_only_last: assert property (chain_far_o != '0 |-> chain_near_o == '0)
		else $error("near and far chain both driven");
endmodule

bind lgc_cell lgc_cell_props #(.BUS_DRIVERS(BUS_DRIVERS)) lgc_cell_props_i (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o,
	.chain_near_o, .chain_far_o, .bus_data_i, .bus_en_i, .bus_o);

// file: verification/lgc_cell_tb_top.sv
// bench for one logic cell: register tasks, fabric drive, compares
// assumes lgc_cell with default parameters and a neighbour model
`timescale 1ns/1ps
module lgc_cell_tb_top
	import lgc_pkg::*;
;
	localparam logic [31:0] RUN = 32'h1 << CTRL_RUN;
	localparam logic [31:0] LFF = 32'h1 << CTRL_LOCAL_REG;
	localparam logic [31:0] GFF = 32'h1 << CTRL_GLOBAL_REG;
	localparam logic [31:0] CAS = 32'h1 << CTRL_CASC_EN;
	localparam logic [31:0] COR = 32'h1 << CTRL_CASC_OR;
	localparam logic [31:0] PAK = 32'h1 << CTRL_PACK;
	localparam logic [31:0] LST = 32'h7 << CTRL_IDX_LO;
	logic          clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, err, lo, go, bo;
	logic          clr_n = 1, pre_n = 1, chip_n = 1;
	logic [7:0]    adr = 8'h00;
	logic [3:0]    sel = 4'h0, op = 4'h0, bd = 4'h0, be = 4'h0, bdat, ben;
	logic [31:0]   wdat = 32'h0, rdat, q;
	lgc_chain_type creq = '0, cin, near, far;
	int            n_mismatch = 0, check_count = 0, k;

	// clock at 200 MHz
	always #2.5 clk_i = ~clk_i;

	lgc_cell lgc_cell_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.operand_in_1_i(op[0]), .operand_in_2_i(op[1]), .operand_in_3_i(op[2]), .operand_in_4_i(op[3]),
		.clear_n_i(clr_n), .preset_n_i(pre_n), .chip_reset_n_i(chip_n), .chain_i(cin),
		.chain_near_o(near), .chain_far_o(far), .local_o(lo), .global_o(go),
		.bus_data_i(bdat), .bus_en_i(ben), .bus_o(bo));
	lgc_nbr_model lgc_nbr_model_i (.clk_i, .rst_i, .chain_req_i(creq), .d_req_i(bd), .en_req_i(be),
		.chain_o(cin), .data_o(bdat), .en_o(ben));

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic cycle, waits for ack or err
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
		int i;
		i = 0;
		@(posedge clk_i);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
		do begin @(posedge clk_i); i++; end while (!(ack || err) && i < 20);
		q = rdat;
		e = err;
		cyc <= 0; stb <= 0; we <= 0;
		if (i >= 20) begin n_mismatch++; print_verdict; end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic e;
		wb(1, a, d, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic e;
		wb(0, a, 32'h0, e);
		chk(q, exp);
	endtask
	task automatic cfg(input logic [15:0] t, input logic [31:0] c);
		wr(ADR_CTRL, 32'h0);
		wr(ADR_TABLE, {16'h0, t});
		wr(ADR_CTRL, c);
		@(negedge clk_i);
	endtask
	// operands and register controls for the next edge
	task automatic drv(input logic [3:0] o, input logic c = 1, p = 1, h = 1);
		@(posedge clk_i);
		op <= o; clr_n <= c; pre_n <= p; chip_n <= h;
		@(negedge clk_i);
	endtask
	task automatic lnk(input lgc_chain_type c, input logic [3:0] d, input logic [3:0] e);
		@(posedge clk_i);
		creq <= c; bd <= d; be <= e;
		@(posedge clk_i);
		@(negedge clk_i);
	endtask

	initial begin
		#200000;
		n_mismatch++;
		print_verdict;
	end

	initial begin
		logic e;
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		rd(ADR_CTRL, 32'h0);
		rd(ADR_TABLE, 32'h0);
		wb(0, 8'h0C, 32'h0, e);
		chk(e, 1);
		$display("test registers done");
		cfg(16'h6996, RUN);
		for (k = 0; k < 16; k++) begin
			drv(k[3:0]);
			chk({lo, go}, {2{^k[3:0]}});
		end
		cfg(16'h6996, RUN | (32'h1 << CTRL_CIN_SEL));
		lnk(2'b10, 4'h0, 4'h0);
		drv(4'h0);
		chk({lo, near}, 3'b110);
		$display("test table done");
		for (k = 0; k < 8; k++) begin
			cfg(16'h6996, RUN | CAS | (k[2] ? COR : 32'h0));
			lnk({1'b0, k[1]}, 4'h0, 4'h0);
			drv({3'b0, k[0]});
			chk(near.cascade, k[2] ? k[0] | k[1] : k[0] & k[1]);
			cfg(16'h6996, RUN | CAS | PAK);
			chk(near.cascade, k[1]);
		end
		cfg(16'h0, RUN | LST);
		lnk(2'b11, 4'h0, 4'h0);
		chk({near, far}, 4'h3);
		rd(ADR_STATUS, 32'h70);
		cfg(16'h0, RUN | LST | (32'h1 << CTRL_MID_LAST));
		chk(far, 0);
		cfg(16'h0, RUN | LST | (32'h1 << CTRL_CHAIN_NEW));
		chk(far, 2'b01);
		$display("test chains done");
		for (k = 0; k < 4; k++) begin
			cfg(16'hFFFF, RUN | LFF | (k << CTRL_FF_LO));
			drv(4'h0, 0);
			drv(4'h0);
			drv(4'h2);
			chk(lo, 1);
			drv(4'h2);
			chk(lo, 4'b1001 >> k & 1);
		end
		cfg(16'hFFFF, RUN | LFF | (32'h1 << CTRL_CE_OP1) | (32'h1 << CTRL_CHIP_RST));
		drv(4'h0, 0);
		drv(4'h0);
		drv(4'h0);
		chk(lo, 0);
		drv(4'h1);
		drv(4'h1);
		chk(lo, 1);
		drv(4'h0, 0);
		drv(4'h0, 1, 0);
		drv(4'h0);
		chk(lo, 1);
		drv(4'h0, 1, 0, 0);
		drv(4'h0);
		chk(lo, 0);
		cfg(16'h6996, RUN | PAK | GFF);
		for (k = 1; k < 10; k += 8) begin
			drv(k[3:0]);
			drv(k[3:0]);
			chk({go, lo}, {k[3], ^k[3:0]});
		end
		$display("test register done");
		cfg(16'hE896, RUN | 32'h1 | CAS);
		for (k = 0; k < 8; k++) begin
			lnk({k[0], 1'b1}, 4'h0, 4'h0);
			drv({2'b0, k[1], k[2]});
			chk({lo, near.carry}, {^k[2:0], k[0] & k[1] | k[0] & k[2] | k[1] & k[2]});
			chk(near.cascade, ^k[2:0]);
		end
		$display("test arithmetic done");
		// up/down counter: load, count up with carry, then borrow when counting down
		cfg(16'h285A, RUN | LFF | 32'h2);
		lnk(2'b00, 4'h0, 4'h0);
		drv(4'h6);
		drv(4'h0);
		chk(lo, 1);
		lnk(2'b10, 4'h0, 4'h0);
		chk({lo, near.carry}, 2'b11);
		drv(4'h8);
		chk({lo, near.carry}, 2'b01);
		// clearable counter: low cascade-in blocks the load, high lets it through
		cfg(16'h285A, RUN | LFF | 32'h3);
		drv(4'h6);
		drv(4'h6);
		chk(lo, 0);
		lnk(2'b11, 4'h0, 4'h0);
		drv(4'h6);
		chk(lo, 1);
		$display("test counters done");
		for (k = 0; k < 16; k++) begin
			lnk(2'b00, 4'hA, k[3:0]);
			chk(bo, k == 0 ? 1 : $countones(k) > 1 ? 0 : |(k[3:0] & 4'hA));
		end
		cfg(16'h1234, RUN);
		wr(ADR_TABLE, 32'h0);
		rd(ADR_TABLE, 32'h1234);
		wr(ADR_CTRL, RUN | 32'h3);
		rd(ADR_CTRL, RUN);
		$display("test bus and lock done");
		print_verdict;
	end
endmodule

// file: verification/lgc_nbr_model.sv
// previous cell and bus drivers facing the cell under test
// assumes requests from the bench; all outputs change just after an edge
`timescale 1ns/1ps
module lgc_nbr_model
	import lgc_pkg::*;
#(
	parameter int N = 4
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// requests from the bench
	input  wire lgc_chain_type chain_req_i,
	input  wire logic [N-1:0]  d_req_i,
	input  wire logic [N-1:0]  en_req_i,
	// toward the cell
	output lgc_chain_type      chain_o,
	output logic [N-1:0]       data_o,
	output logic [N-1:0]       en_o
);
	// previous cell chain outputs
	always_ff @(posedge clk_i) begin
		chain_o <= rst_i ? '0 : chain_req_i;
	end
	// released drivers flip each cycle so stale data is never trusted
	always_ff @(posedge clk_i) begin
		en_o   <= rst_i ? '0 : en_req_i;
		data_o <= rst_i ? '0 : (en_req_i & d_req_i) | (~en_req_i & ~data_o);
	end
endmodule
